// ### rtl/pos_consts.vh
`ifndef POS_CONSTS_VH
`define POS_CONSTS_VH

// Command codes seen on the command port.
`define POS_CMD_CLEAR_FAULTS 8'h03
`define POS_CMD_ALERT_MASK 8'h1B
`define POS_CMD_STATUS_BYTE 8'h78
`define POS_CMD_STATUS_WORD 8'h79
`define POS_CMD_OUTPUT_VOLTAGE_STATUS 8'h7A
`define POS_CMD_OUTPUT_CURRENT_STATUS 8'h7B
`define POS_CMD_ALERT_MASK_EXT 8'hE0

// Positions in the latched flag vector.
`define POS_VOUT_LSB 0
`define POS_IOUT_LSB 8
`define POS_BIT_OVF 7
`define POS_BIT_OVW 6
`define POS_BIT_UVW 5
`define POS_BIT_UVF 4
`define POS_BIT_LIMIT 3
`define POS_BIT_TON 2
`define POS_BIT_OCF 15
`define POS_BIT_OCW 13
`define POS_BIT_UCF 12
`define POS_BIT_BUSY 16
`define POS_BIT_UNKNOWN 17

// Implemented flags: output voltage 7:2, output current 7, 5, 4, busy and unknown.
`define POS_FLAG_IMPL 18'h3B0FC
`define POS_VOUT_IMPL 8'hFC
`define POS_IOUT_IMPL 8'hB0
`define POS_BYTE_IMPL 8'h81
`define POS_EXT_IMPL 3'h7

// Status summary fields.
`define POS_SBYTE_BUSY 7
`define POS_SBYTE_UNKNOWN 0

// Special write values of the summary word and byte.
`define POS_WORD_CLR_BUSY 16'h0080
`define POS_WORD_CLR_BOTH 16'h0180
`define POS_BYTE_CLR_BUSY 8'h80

// Reset values.
`define POS_RST_FLAG 1'h0
`define POS_RST_MASK 8'h00
`define POS_RST_EXT 3'h0
`define POS_RST_DATA 16'h0000

`endif

// ### rtl/pos_flag.v
`timescale 1ns/10ps
`default_nettype none

module pos_flag (
  input wire sys_clk_i,
  input wire rst_n_i,
  input wire set_i,
  input wire clr_i,
  output reg flag_o
);

  `include "pos_consts.vh"

  reg next_flag;

  // A set in the same cycle as a clear wins, so no event is lost.
  always @* begin
    next_flag = flag_o;
    if (set_i) begin
      next_flag = 1'h1;
    end else if (clr_i) begin
      next_flag = 1'h0;
    end
  end

  always @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      flag_o <= `POS_RST_FLAG;
    end else begin
      flag_o <= next_flag;
    end
  end

endmodule

`default_nettype wire

// ### rtl/pos_top.v
`timescale 1ns/10ps
`default_nettype none

module pos_top (
  input wire sys_clk_i,
  input wire rst_n_i,
  input wire cmd_valid_i,
  input wire cmd_write_i,
  input wire [7:0] cmd_code_i,
  input wire [15:0] cmd_data_i,
  input wire ovp_fixed_i,
  input wire ovp_track_i,
  input wire ovp_prebias_i,
  input wire out_overvolt_warn_i,
  input wire out_undervolt_warn_i,
  input wire out_undervolt_fault_i,
  input wire out_level_limit_violation_i,
  input wire turn_on_time_exceeded_i,
  input wire out_overcurrent_fault_i,
  input wire out_overcurrent_warn_i,
  input wire out_undercurrent_fault_i,
  input wire busy_fault_i,
  input wire unknown_fault_i,
  input wire conv_off_i,
  input wire [2:0] byte_live_i,
  input wire [3:0] word_live_i,
  output reg rsp_valid_o,
  output reg [15:0] rsp_data_o,
  output reg alert_o
);

  `include "pos_consts.vh"

  localparam [17:0] FLAG_IMPL = `POS_FLAG_IMPL;

  wire ovf_any;
  wire [17:0] set_vec;
  wire [17:0] flags;
  wire wr_cmd;
  wire rd_cmd;
  wire [7:0] vout_view;
  wire [7:0] iout_view;
  wire [7:0] sbyte_view;
  wire [15:0] sword_view;

  reg [17:0] next_clr;
  reg [7:0] vout_mask;
  reg [7:0] iout_mask;
  reg [7:0] byte_mask;
  reg [2:0] ext_mask;
  reg [2:0] ovf_src;
  reg [2:0] next_ovf_src;
  reg [7:0] next_vout_mask;
  reg [7:0] next_iout_mask;
  reg [7:0] next_byte_mask;
  reg [2:0] next_ext_mask;
  reg [15:0] next_rsp_data;
  reg [7:0] mask_view;
  reg ovf_alert;
  reg other_alert;
  reg next_alert;

  assign wr_cmd = cmd_valid_i & cmd_write_i;
  assign rd_cmd = cmd_valid_i & ~cmd_write_i;

  // Any of the three protection sources raises the overvoltage fault.
  assign ovf_any = ovp_fixed_i | ovp_track_i | ovp_prebias_i;

  // Detector events placed at their flag positions.
  assign set_vec[`POS_BIT_OVF] = ovf_any;
  assign set_vec[`POS_BIT_OVW] = out_overvolt_warn_i;
  assign set_vec[`POS_BIT_UVW] = out_undervolt_warn_i;
  assign set_vec[`POS_BIT_UVF] = out_undervolt_fault_i;
  assign set_vec[`POS_BIT_LIMIT] = out_level_limit_violation_i;
  assign set_vec[`POS_BIT_TON] = turn_on_time_exceeded_i;
  assign set_vec[1:0] = 2'h0;
  assign set_vec[`POS_BIT_OCF] = out_overcurrent_fault_i;
  assign set_vec[14] = 1'h0;
  assign set_vec[`POS_BIT_OCW] = out_overcurrent_warn_i;
  assign set_vec[`POS_BIT_UCF] = out_undercurrent_fault_i;
  assign set_vec[11:8] = 4'h0;
  assign set_vec[`POS_BIT_BUSY] = busy_fault_i;
  assign set_vec[`POS_BIT_UNKNOWN] = unknown_fault_i;

  // One latched cell per implemented flag; unimplemented positions stay zero.
  genvar gi;
  generate
    for (gi = 0; gi < 18; gi = gi + 1) begin : g_flag
      if (FLAG_IMPL[gi]) begin : g_impl
        pos_flag u_flag (
          .sys_clk_i(sys_clk_i),
          .rst_n_i(rst_n_i),
          .set_i(set_vec[gi]),
          .clr_i(next_clr[gi]),
          .flag_o(flags[gi])
        );
      end else begin : g_none
        assign flags[gi] = 1'h0;
      end
    end
  endgenerate

  // Clear strobes decoded from host writes.
  always @* begin
    next_clr = 18'h00000;
    if (wr_cmd) begin
      case (cmd_code_i)
        `POS_CMD_CLEAR_FAULTS: begin
          next_clr = FLAG_IMPL;
        end
        `POS_CMD_OUTPUT_VOLTAGE_STATUS: begin
          next_clr[7:0] = cmd_data_i[7:0] & `POS_VOUT_IMPL;
        end
        `POS_CMD_OUTPUT_CURRENT_STATUS: begin
          next_clr[15:8] = cmd_data_i[7:0] & `POS_IOUT_IMPL;
        end
        `POS_CMD_STATUS_WORD: begin
          if (cmd_data_i == `POS_WORD_CLR_BUSY) begin
            next_clr[`POS_BIT_BUSY] = 1'h1;
          end else if (cmd_data_i == `POS_WORD_CLR_BOTH) begin
            next_clr[`POS_BIT_BUSY] = 1'h1;
            next_clr[`POS_BIT_UNKNOWN] = 1'h1;
          end
        end
        `POS_CMD_STATUS_BYTE: begin
          if (cmd_data_i[7:0] == `POS_BYTE_CLR_BUSY) begin
            next_clr[`POS_BIT_BUSY] = 1'h1;
          end
        end
        default: begin
          next_clr = 18'h00000;
        end
      endcase
    end
  end

  // Which overvoltage sources were seen since the fault flag was last cleared.
  always @* begin
    next_ovf_src = ovf_src;
    if (next_clr[`POS_BIT_OVF]) begin
      next_ovf_src = 3'h0;
    end
    next_ovf_src = next_ovf_src | {ovp_prebias_i, ovp_track_i, ovp_fixed_i};
  end

  // Register views.
  assign vout_view = {flags[7:2], 2'h0};
  assign iout_view = {flags[15], 1'h0, flags[13:12], 4'h0};
  assign sbyte_view = {flags[`POS_BIT_BUSY], conv_off_i, flags[`POS_BIT_OVF],
                       flags[`POS_BIT_OCF], byte_live_i, flags[`POS_BIT_UNKNOWN]};
  assign sword_view = {|flags[7:0], |flags[15:8], word_live_i[3:1], 1'h0,
                       word_live_i[0], 1'h0, sbyte_view};

  // Mask register updates; each POS_CMD_ALERT_MASK write targets the status code in its low byte.
  always @* begin
    next_vout_mask = vout_mask;
    next_iout_mask = iout_mask;
    next_byte_mask = byte_mask;
    next_ext_mask = ext_mask;
    if (wr_cmd && cmd_code_i == `POS_CMD_ALERT_MASK) begin
      case (cmd_data_i[7:0])
        `POS_CMD_OUTPUT_VOLTAGE_STATUS: begin
          next_vout_mask = cmd_data_i[15:8] & `POS_VOUT_IMPL;
        end
        `POS_CMD_OUTPUT_CURRENT_STATUS: begin
          next_iout_mask = cmd_data_i[15:8] & `POS_IOUT_IMPL;
        end
        `POS_CMD_STATUS_BYTE: begin
          next_byte_mask = cmd_data_i[15:8] & `POS_BYTE_IMPL;
        end
        `POS_CMD_STATUS_WORD: begin
          next_byte_mask = cmd_data_i[15:8] & `POS_BYTE_IMPL;
        end
        default: begin
          next_byte_mask = byte_mask;
        end
      endcase
    end
    if (wr_cmd && cmd_code_i == `POS_CMD_ALERT_MASK_EXT) begin
      next_ext_mask = cmd_data_i[2:0] & `POS_EXT_IMPL;
    end
  end

  // Mask readback picks the register named in the low data byte.
  always @* begin
    case (cmd_data_i[7:0])
      `POS_CMD_OUTPUT_VOLTAGE_STATUS: begin
        mask_view = vout_mask;
      end
      `POS_CMD_OUTPUT_CURRENT_STATUS: begin
        mask_view = iout_mask;
      end
      `POS_CMD_STATUS_BYTE: begin
        mask_view = byte_mask;
      end
      `POS_CMD_STATUS_WORD: begin
        mask_view = byte_mask;
      end
      default: begin
        mask_view = 8'h00;
      end
    endcase
  end

  // Read answers; unknown codes answer zero.
  always @* begin
    case (cmd_code_i)
      `POS_CMD_STATUS_BYTE: begin
        next_rsp_data = {8'h00, sbyte_view};
      end
      `POS_CMD_STATUS_WORD: begin
        next_rsp_data = sword_view;
      end
      `POS_CMD_OUTPUT_VOLTAGE_STATUS: begin
        next_rsp_data = {8'h00, vout_view};
      end
      `POS_CMD_OUTPUT_CURRENT_STATUS: begin
        next_rsp_data = {8'h00, iout_view};
      end
      `POS_CMD_ALERT_MASK: begin
        next_rsp_data = {8'h00, mask_view};
      end
      `POS_CMD_ALERT_MASK_EXT: begin
        next_rsp_data = {13'h0000, ext_mask};
      end
      default: begin
        next_rsp_data = `POS_RST_DATA;
      end
    endcase
  end

  // Alert from unmasked latched flags; overvoltage also honours the extended mask.
  always @* begin
    ovf_alert = flags[`POS_BIT_OVF] & ~vout_mask[7] & (|(ovf_src & ~ext_mask));
    other_alert = (|(flags[6:2] & ~vout_mask[6:2])) |
                  (|(flags[15:8] & ~iout_mask)) |
                  (flags[`POS_BIT_BUSY] & ~byte_mask[`POS_SBYTE_BUSY]) |
                  (flags[`POS_BIT_UNKNOWN] & ~byte_mask[`POS_SBYTE_UNKNOWN]);
    next_alert = ovf_alert | other_alert;
  end

  always @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      vout_mask <= `POS_RST_MASK;
      iout_mask <= `POS_RST_MASK;
      byte_mask <= `POS_RST_MASK;
      ext_mask <= `POS_RST_EXT;
      ovf_src <= `POS_RST_EXT;
      rsp_valid_o <= 1'h0;
      rsp_data_o <= `POS_RST_DATA;
      alert_o <= 1'h0;
    end else begin
      vout_mask <= next_vout_mask;
      iout_mask <= next_iout_mask;
      byte_mask <= next_byte_mask;
      ext_mask <= next_ext_mask;
      ovf_src <= next_ovf_src;
      rsp_valid_o <= rd_cmd;
      if (rd_cmd) begin
        rsp_data_o <= next_rsp_data;
      end
      alert_o <= next_alert;
    end
  end

endmodule

`default_nettype wire

// ### dv/pos_top_properties.sv
`timescale 1ns/10ps
`default_nettype none
module pos_top_chk (
  input wire sys_clk_i,
  input wire rst_n_i,
  input wire cmd_valid_i,
  input wire cmd_write_i,
  input wire [7:0] cmd_code_i,
  input wire ovp_fixed_i,
  input wire out_overcurrent_fault_i,
  input wire rsp_valid_o,
  input wire [15:0] rsp_data_o,
  input wire alert_o
);
  wire rd = cmd_valid_i && !cmd_write_i;
  wire wr = cmd_valid_i && cmd_write_i;
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);
  chk_read_answer: assert property (rd |=> rsp_valid_o)
    else $error("read got no answer");
  chk_no_answer: assert property (!rd |=> !rsp_valid_o)
    else $error("answer without read");
  chk_word_bit8: assert property (rd && cmd_code_i == 8'h79 |=> !rsp_data_o[8])
    else $error("word bit 8 set");
  chk_vout_unused: assert property (rd && cmd_code_i == 8'h7A |=>
    rsp_data_o[15:8] == 8'h00 && rsp_data_o[1:0] == 2'h0)
    else $error("voltage status unused bits set");
  chk_iout_unused: assert property (rd && cmd_code_i == 8'h7B |=>
    !rsp_data_o[6] && rsp_data_o[3:0] == 4'h0)
    else $error("current status unused bits set");
  chk_data_hold: assert property (!rsp_valid_o |-> rsp_data_o == $past(rsp_data_o))
    else $error("read data moved without answer");
  chk_ovf_set: assert property (ovp_fixed_i ##1 (rd && cmd_code_i == 8'h7A) |=>
    rsp_data_o[7])
    else $error("overvoltage fault not latched");
  chk_ocf_set: assert property (out_overcurrent_fault_i ##1 (rd && cmd_code_i == 8'h7B) |=>
    rsp_data_o[7])
    else $error("overcurrent fault not latched");
  chk_alert_fall: assert property ($fell(alert_o) |-> $past(wr) || $past(wr, 2))
    else $error("alert dropped without a write");
endmodule
bind pos_top pos_top_chk i_pos_top_chk (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i),
  .cmd_valid_i(cmd_valid_i), .cmd_write_i(cmd_write_i), .cmd_code_i(cmd_code_i),
  .ovp_fixed_i(ovp_fixed_i), .out_overcurrent_fault_i(out_overcurrent_fault_i),
  .rsp_valid_o(rsp_valid_o), .rsp_data_o(rsp_data_o), .alert_o(alert_o));
`default_nettype wire

// ### dv/pos_host.sv
`timescale 1ns/10ps
`default_nettype none
module pos_host (
  input wire logic sys_clk_i,
  input wire logic rsp_valid_i,
  input wire logic [15:0] rsp_data_i,
  output logic cmd_valid_o,
  output logic cmd_write_o,
  output logic [7:0] cmd_code_o,
  output logic [15:0] cmd_data_o
);
  int timeouts = 0;
  initial begin
    cmd_valid_o = 1'b0;
    cmd_write_o = 1'b0;
    cmd_code_o = 8'h00;
    cmd_data_o = 16'h0000;
  end
  // Reads and writes share one strobe; released lines show inverted junk.
  task automatic wr(input logic w, input logic [7:0] c, input logic [15:0] d);
    @(posedge sys_clk_i);
    #1;
    cmd_valid_o = 1'b1;
    cmd_write_o = w;
    cmd_code_o = c;
    cmd_data_o = d;
    @(posedge sys_clk_i);
    #1;
    cmd_valid_o = 1'b0;
    cmd_write_o = ~w;
    cmd_code_o = ~c;
    cmd_data_o = ~d;
  endtask
  task automatic rd(input logic [7:0] c, output logic [15:0] d);
    int i;
    wr(1'b0, c, 16'h0000);
    for (i = 0; i < 4 && rsp_valid_i !== 1'b1; i++) begin
      @(posedge sys_clk_i);
      #1;
    end
    if (rsp_valid_i !== 1'b1) timeouts++;
    d = rsp_data_i;
  endtask
endmodule
`default_nettype wire

// ### dv/tb.sv
`timescale 1ns/10ps
`default_nettype none
module tb;
  logic sys_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic cmd_valid, cmd_write, rsp_valid, alert, conv_off = 1'b0;
  logic [7:0] cmd_code, c, m;
  logic [15:0] cmd_data, rsp_data, rdat;
  logic [12:0] ev = 13'h0000;
  logic [2:0] byte_live = 3'h0;
  logic [3:0] word_live = 4'h0;
  int errors = 0;
  int comparisons = 0;
  int i;
  int eb[9] = '{0, 3, 4, 5, 6, 7, 8, 9, 10};
  int bb[9] = '{7, 6, 5, 4, 3, 2, 7, 5, 4};
  always #2.5 sys_clk_i = ~sys_clk_i;
  pos_top i_pos_top (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .cmd_valid_i(cmd_valid),
    .cmd_write_i(cmd_write), .cmd_code_i(cmd_code), .cmd_data_i(cmd_data),
    .ovp_fixed_i(ev[0]), .ovp_track_i(ev[1]), .ovp_prebias_i(ev[2]),
    .out_overvolt_warn_i(ev[3]), .out_undervolt_warn_i(ev[4]), .out_undervolt_fault_i(ev[5]),
    .out_level_limit_violation_i(ev[6]), .turn_on_time_exceeded_i(ev[7]),
    .out_overcurrent_fault_i(ev[8]), .out_overcurrent_warn_i(ev[9]),
    .out_undercurrent_fault_i(ev[10]), .busy_fault_i(ev[11]), .unknown_fault_i(ev[12]),
    .conv_off_i(conv_off), .byte_live_i(byte_live), .word_live_i(word_live),
    .rsp_valid_o(rsp_valid), .rsp_data_o(rsp_data), .alert_o(alert));
  pos_host i_pos_host (.sys_clk_i(sys_clk_i), .rsp_valid_i(rsp_valid), .rsp_data_i(rsp_data),
    .cmd_valid_o(cmd_valid), .cmd_write_o(cmd_write), .cmd_code_o(cmd_code),
    .cmd_data_o(cmd_data));
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rdc(input logic [7:0] code, input logic [15:0] exp);
    i_pos_host.rd(code, rdat);
    check(rdat, exp);
  endtask
  task automatic finish_test;
    errors += i_pos_host.timeouts;
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    #100000;
    errors++;
    finish_test;
  end
  initial begin
    repeat (6) @(posedge sys_clk_i);
    #1 rst_n_i = 1'b1;
    rdc(8'h7A, 16'h0000);
    conv_off = 1'b1;
    byte_live = 3'h5;
    word_live = 4'hF;
    rdc(8'h78, 16'h004A);
    rdc(8'h79, 16'h3A4A);
    conv_off = 1'b0;
    byte_live = 3'h0;
    word_live = 4'h0;
    for (i = 0; i < 9; i++) begin
      c = (i < 6) ? 8'h7A : 8'h7B;
      m = 8'h01 << bb[i];
      ev[eb[i]] = 1'b1;
      rdc(c, {8'h00, m});
      ev[eb[i]] = 1'b0;
      rdc(c, {8'h00, m});
      check({15'h0000, alert}, 16'h0001);
      rdc(8'h79, {i < 6, i >= 6, 6'h00, i == 0 ? 8'h20 : (i == 6 ? 8'h10 : 8'h00)});
      i_pos_host.wr(1'b1, c, {8'h00, ~m});
      rdc(c, {8'h00, m});
      i_pos_host.wr(1'b1, c, {8'h00, m});
      rdc(c, 16'h0000);
      check({15'h0000, alert}, 16'h0000);
    end
    ev = 13'h07FF;
    rdc(8'h7A, 16'h00FC);
    ev = 13'h0000;
    rdc(8'h7B, 16'h00B0);
    i_pos_host.wr(1'b1, 8'h03, 16'h0000);
    rdc(8'h7A, 16'h0000);
    rdc(8'h7B, 16'h0000);
    ev = 13'h1800;
    rdc(8'h78, 16'h0081);
    ev = 13'h0000;
    i_pos_host.wr(1'b1, 8'h79, 16'h0080);
    rdc(8'h79, 16'h0001);
    ev[11] = 1'b1;
    rdc(8'h78, 16'h0081);
    ev[11] = 1'b0;
    i_pos_host.wr(1'b1, 8'h79, 16'h0180);
    rdc(8'h79, 16'h0000);
    ev[11] = 1'b1;
    rdc(8'h78, 16'h0080);
    ev[11] = 1'b0;
    i_pos_host.wr(1'b1, 8'h78, 16'h0080);
    rdc(8'h78, 16'h0000);
    i_pos_host.wr(1'b1, 8'h1B, 16'h807A);
    ev[1] = 1'b1;
    rdc(8'h7A, 16'h0080);
    ev[1] = 1'b0;
    check({15'h0000, alert}, 16'h0000);
    i_pos_host.wr(1'b1, 8'h7A, 16'h0080);
    i_pos_host.wr(1'b1, 8'h1B, 16'h007A);
    ev[0] = 1'b1;
    rdc(8'h7A, 16'h0080);
    ev[0] = 1'b0;
    check({15'h0000, alert}, 16'h0001);
    i_pos_host.wr(1'b1, 8'hE0, 16'h0001);
    rdc(8'hE0, 16'h0001);
    check({15'h0000, alert}, 16'h0000);
    ev[2] = 1'b1;
    rdc(8'h7A, 16'h0080);
    ev[2] = 1'b0;
    check({15'h0000, alert}, 16'h0001);
    i_pos_host.wr(1'b1, 8'h03, 16'h0000);
    rdc(8'h7A, 16'h0000);
    finish_test;
  end
endmodule
`default_nettype wire
